//--- inc/timer_consts.svh
// Register offsets, field positions, reset values and edge codes of the capture/compare timer.
// Assumes an APB slave with 32-bit data and word-aligned byte addresses.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH
`define ADDR_MODE_CTRL 12'h000
`define ADDR_OUT_CTRL 12'h004
`define ADDR_CAP_CTRL 12'h008
`define ADDR_COUNT 12'h00c
`define ADDR_CAPCMP_A 12'h010
`define ADDR_CAPCMP_B 12'h014
`define ADDR_STATUS 12'h018
`define MODE_LSB 0
`define MODE_MSB 1
`define OVF_BIT 2
`define OUT_ENABLE_BIT 0
`define OSP_ENABLE_BIT 1
`define OSP_TRIGGER_BIT 2
`define OUT_INV_A_BIT 3
`define OUT_INV_B_BIT 4
`define EDGE_A_LSB 0
`define EDGE_A_MSB 1
`define EDGE_B_LSB 2
`define EDGE_B_MSB 3
`define CAPA_SEL_BIT 4
`define CAPA_CAPTURE_BIT 5
`define CAPB_CAPTURE_BIT 6
`define STAT_IRQ_A_BIT 0
`define STAT_IRQ_B_BIT 1
`define STAT_PIN_BIT 2
`define STAT_PULSE_BUSY_BIT 3
`define COUNT_ZERO 16'h0000
`define COUNT_MAX 16'hffff
`define EDGE_FALL 2'h0
`define EDGE_RISE 2'h1
`define EDGE_BOTH 2'h3
`endif

//--- inc/timer_pkg.sv
// Types shared by the timer core and its edge detector.
// Assumes nothing beyond the consts header.
package timer_pkg;
    typedef enum logic [1:0] {
        MODE_STOP,
        MODE_FREE,
        MODE_EDGE_CLEAR,
        MODE_MATCH_CLEAR
    } op_mode_type;
    typedef enum {
        PULSE_IDLE,
        PULSE_ACTIVE
    } pulse_state_type;
endpackage

//--- inc/edge_if.sv
// Interface between the trigger edge detector and the timer core.
// Assumes both ends sit on the same clock.
interface edge_if;
    logic [1:0] edge_sel_a;
    logic [1:0] edge_sel_b;
    logic valid_a;
    logic opposite_a;
    logic valid_b;
    modport detector (input edge_sel_a, input edge_sel_b, output valid_a, output opposite_a, output valid_b);
    modport core (output edge_sel_a, output edge_sel_b, input valid_a, input opposite_a, input valid_b);
endinterface

//--- core/trigger_edges.sv
// Synchronises the two trigger pins and reports valid edges of both and opposite edges of pin A.
// Assumes the pins are asynchronous to the system clock.
`include "timer_consts.svh"
module trigger_edges
    import timer_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // Raw trigger pins.
    input wire logic pin_a,
    input wire logic pin_b,
    // Edge reports.
    edge_if.detector edges
);
    logic [2:0] sync_a_r;
    logic [2:0] sync_b_r;
    logic level_a_r;
    logic level_b_r;
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;

    function automatic logic is_valid(input logic [1:0] sel, input logic rise, input logic fall);
        case (sel)
            `EDGE_FALL: is_valid = fall;
            `EDGE_RISE: is_valid = rise;
            `EDGE_BOTH: is_valid = rise | fall;
            default: is_valid = 1'b0;
        endcase
    endfunction

    // A change counts only once the second and third stages agree, which filters a one-stage glitch.
    always_ff @(posedge clk) begin
        if (reset) begin
            sync_a_r <= 3'h0;
            sync_b_r <= 3'h0;
            level_a_r <= 1'b0;
            level_b_r <= 1'b0;
        end else begin
            sync_a_r <= {sync_a_r[1:0], pin_a};
            sync_b_r <= {sync_b_r[1:0], pin_b};
            if (sync_a_r[1] == sync_a_r[2]) begin
                level_a_r <= sync_a_r[2];
            end
            if (sync_b_r[1] == sync_b_r[2]) begin
                level_b_r <= sync_b_r[2];
            end
        end
    end

    always_comb begin
        rise_a = (sync_a_r[1] == sync_a_r[2]) && sync_a_r[2] && !level_a_r;
        fall_a = (sync_a_r[1] == sync_a_r[2]) && !sync_a_r[2] && level_a_r;
        rise_b = (sync_b_r[1] == sync_b_r[2]) && sync_b_r[2] && !level_b_r;
        fall_b = (sync_b_r[1] == sync_b_r[2]) && !sync_b_r[2] && level_b_r;
    end

    assign edges.valid_a = is_valid(edges.edge_sel_a, rise_a, fall_a);
    assign edges.valid_b = is_valid(edges.edge_sel_b, rise_b, fall_b);
    // With both edges selected there is no opposite edge, so opposite reports nothing.
    assign edges.opposite_a = (edges.edge_sel_a == `EDGE_RISE) ? fall_a :
                              (edges.edge_sel_a == `EDGE_FALL) ? rise_a : 1'b0;
endmodule

//--- core/capture_timer.sv
// 16-bit capture/compare timer with programmable pulse, single pulse and width capture.
// Assumes an APB master on the system clock and asynchronous trigger pins.
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`include "timer_consts.svh"
module capture_timer
    import timer_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset.
    input wire logic CLK_SYS,
    input wire logic RESET,
    // APB slave.
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Trigger pins.
    input wire logic TRIGGER_INPUT_A,
    input wire logic TRIGGER_INPUT_B,
    // Pulse pin and match or capture requests.
    output logic PULSE_OUTPUT_PIN,
    output logic MATCH_CAPTURE_IRQ_A,
    output logic MATCH_CAPTURE_IRQ_B
);
    edge_if edges ();

    op_mode_type op_mode_r;
    pulse_state_type pulse_state_r;
    logic [WIDTH-1:0] count_register_r;
    logic [WIDTH-1:0] capcmp_reg_a_r;
    logic [WIDTH-1:0] capcmp_reg_b_r;
    logic overflow_flag_r;
    logic out_enable_r;
    logic single_pulse_enable_r;
    logic out_inv_a_r;
    logic out_inv_b_r;
    logic [1:0] edge_sel_a_r;
    logic [1:0] edge_sel_b_r;
    logic capa_sel_r;
    logic capa_capture_r;
    logic capb_capture_r;
    logic pin_r;
    logic irq_a_r;
    logic irq_b_r;
    logic [31:0] prdata_r;

    logic wr_en;
    logic rd_en;
    logic running;
    logic osp_mode;
    logic osp_trig;
    logic match_a;
    logic match_b;
    logic cap_a_evt;
    logic cap_b_evt;
    logic clear_count;
    logic wrap;
    logic [WIDTH-1:0] count_nxt;
    logic osp_end;
    logic pin_nxt;
    logic [31:0] read_val;

    // One decoder for every register strobe keeps the address compare in a single place.
    function automatic logic hits(input logic strobe, input logic [11:0] addr, input logic [11:0] want);
        hits = strobe && addr == want;
    endfunction

    trigger_edges u_edges (
        .clk(CLK_SYS),
        .reset(RESET),
        .pin_a(TRIGGER_INPUT_A),
        .pin_b(TRIGGER_INPUT_B),
        .edges(edges.detector)
    );

    assign edges.edge_sel_a = edge_sel_a_r;
    assign edges.edge_sel_b = edge_sel_b_r;

    // Every access completes in its first access cycle, so pready is tied high.
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;
    assign PRDATA = prdata_r;
    assign wr_en = PSEL && PENABLE && PWRITE;
    assign rd_en = PSEL && !PENABLE && !PWRITE;

    assign running = (op_mode_r != MODE_STOP);
    assign osp_mode = single_pulse_enable_r &&
                      (op_mode_r == MODE_FREE || op_mode_r == MODE_EDGE_CLEAR);
    // The pin edge does double duty in mode 10, but only once the single pulse is enabled.
    assign osp_trig = running && osp_mode &&
                      ((hits(wr_en, PADDR, `ADDR_OUT_CTRL) && PWDATA[`OSP_TRIGGER_BIT]) ||
                       edges.valid_a);
    assign match_a = running && !capa_capture_r && count_register_r == capcmp_reg_a_r;
    assign match_b = running && !capb_capture_r && count_register_r == capcmp_reg_b_r;
    assign cap_a_evt = running && capa_capture_r &&
                       (capa_sel_r ? edges.valid_b : edges.opposite_a);
    assign cap_b_evt = running && capb_capture_r && edges.valid_a;
    assign clear_count = osp_trig ||
                         (op_mode_r == MODE_EDGE_CLEAR && edges.valid_a) ||
                         (op_mode_r == MODE_MATCH_CLEAR && match_a);
    assign wrap = running && !clear_count && count_register_r == `COUNT_MAX;
    // The pulse ends at whichever compare value the count reaches later.
    assign osp_end = (capcmp_reg_a_r > capcmp_reg_b_r) ? match_a : match_b;

    always_comb begin
        count_nxt = count_register_r;
        if (!running) begin
            count_nxt = `COUNT_ZERO;
        end else if (clear_count) begin
            count_nxt = `COUNT_ZERO;
        end else begin
            count_nxt = count_register_r + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            count_register_r <= `COUNT_ZERO;
        end else begin
            count_register_r <= count_nxt;
        end
    end

    // A wrap by match at the maximum value counts as overflow too; the set beats a clear in the same cycle.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            overflow_flag_r <= 1'b0;
        end else if (wrap || (op_mode_r == MODE_MATCH_CLEAR && match_a && count_register_r == `COUNT_MAX)) begin
            overflow_flag_r <= 1'b1;
        end else if (hits(wr_en, PADDR, `ADDR_MODE_CTRL) && !PWDATA[`OVF_BIT]) begin
            overflow_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            op_mode_r <= MODE_STOP;
        end else if (hits(wr_en, PADDR, `ADDR_MODE_CTRL)) begin
            op_mode_r <= op_mode_type'(PWDATA[`MODE_MSB:`MODE_LSB]);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            out_enable_r <= 1'b0;
        end else if (hits(wr_en, PADDR, `ADDR_OUT_CTRL)) begin
            out_enable_r <= PWDATA[`OUT_ENABLE_BIT];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            single_pulse_enable_r <= 1'b0;
        end else if (hits(wr_en, PADDR, `ADDR_OUT_CTRL)) begin
            single_pulse_enable_r <= PWDATA[`OSP_ENABLE_BIT];
        end
    end

    // The inversion bits steer the pin only in free-running and edge-clear modes without a single pulse.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            out_inv_a_r <= 1'b0;
        end else if (hits(wr_en, PADDR, `ADDR_OUT_CTRL)) begin
            out_inv_a_r <= PWDATA[`OUT_INV_A_BIT];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            out_inv_b_r <= 1'b0;
        end else if (hits(wr_en, PADDR, `ADDR_OUT_CTRL)) begin
            out_inv_b_r <= PWDATA[`OUT_INV_B_BIT];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            edge_sel_a_r <= `EDGE_FALL;
        end else if (hits(wr_en, PADDR, `ADDR_CAP_CTRL)) begin
            edge_sel_a_r <= PWDATA[`EDGE_A_MSB:`EDGE_A_LSB];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            edge_sel_b_r <= `EDGE_FALL;
        end else if (hits(wr_en, PADDR, `ADDR_CAP_CTRL)) begin
            edge_sel_b_r <= PWDATA[`EDGE_B_MSB:`EDGE_B_LSB];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            capa_sel_r <= 1'b0;
        end else if (hits(wr_en, PADDR, `ADDR_CAP_CTRL)) begin
            capa_sel_r <= PWDATA[`CAPA_SEL_BIT];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            capa_capture_r <= 1'b0;
        end else if (hits(wr_en, PADDR, `ADDR_CAP_CTRL)) begin
            capa_capture_r <= PWDATA[`CAPA_CAPTURE_BIT];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            capb_capture_r <= 1'b0;
        end else if (hits(wr_en, PADDR, `ADDR_CAP_CTRL)) begin
            capb_capture_r <= PWDATA[`CAPB_CAPTURE_BIT];
        end
    end

    // Capture wins over a software write landing in the same cycle, since the event cannot repeat.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            capcmp_reg_a_r <= `COUNT_ZERO;
        end else if (cap_a_evt) begin
            capcmp_reg_a_r <= count_register_r;
        end else if (hits(wr_en, PADDR, `ADDR_CAPCMP_A)) begin
            capcmp_reg_a_r <= PWDATA[WIDTH-1:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            capcmp_reg_b_r <= `COUNT_ZERO;
        end else if (cap_b_evt) begin
            capcmp_reg_b_r <= count_register_r;
        end else if (hits(wr_en, PADDR, `ADDR_CAPCMP_B)) begin
            capcmp_reg_b_r <= PWDATA[WIDTH-1:0];
        end
    end

    // Requests are one-cycle pulses; an external controller latches them.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            irq_a_r <= 1'b0;
        end else begin
            irq_a_r <= match_a || cap_a_evt;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            irq_b_r <= 1'b0;
        end else begin
            irq_b_r <= match_b || cap_b_evt;
        end
    end

    // The busy state gates the single-pulse toggles and shows in status; a retrigger during it is the caller's fault and restarts.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pulse_state_r <= PULSE_IDLE;
        end else begin
            case (pulse_state_r)
                PULSE_IDLE: begin
                    if (osp_trig) begin
                        pulse_state_r <= PULSE_ACTIVE;
                    end
                end
                PULSE_ACTIVE: begin
                    if (!osp_mode || osp_end) begin
                        pulse_state_r <= PULSE_IDLE;
                    end
                end
                default: pulse_state_r <= PULSE_IDLE;
            endcase
        end
    end

    // Pulse mode sets the pin at the restart and drops it after B plus one clocks.
    // A single pulse toggles only while armed, so a later wrap past the compare values stays quiet.
    always_comb begin
        pin_nxt = pin_r;
        if (!running || !out_enable_r) begin
            pin_nxt = 1'b0;
        end else if (op_mode_r == MODE_MATCH_CLEAR) begin
            if (match_a) begin
                pin_nxt = 1'b1;
            end else if (match_b) begin
                pin_nxt = 1'b0;
            end
        end else if (osp_mode) begin
            if (pulse_state_r == PULSE_ACTIVE && (match_a != match_b)) begin
                pin_nxt = ~pin_r;
            end
        end else if ((match_a && out_inv_a_r) != (match_b && out_inv_b_r)) begin
            pin_nxt = ~pin_r;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            pin_r <= 1'b0;
        end else begin
            pin_r <= pin_nxt;
        end
    end
    assign PULSE_OUTPUT_PIN = pin_r;
    assign MATCH_CAPTURE_IRQ_A = irq_a_r;
    assign MATCH_CAPTURE_IRQ_B = irq_b_r;

    // The count is only sampled here, never touched, so a read cannot disturb counting.
    always_comb begin
        case (PADDR)
            `ADDR_MODE_CTRL: read_val = {29'h0, overflow_flag_r, op_mode_r};
            `ADDR_OUT_CTRL: read_val = {27'h0, out_inv_b_r, out_inv_a_r, 1'b0,
                                        single_pulse_enable_r, out_enable_r};
            `ADDR_CAP_CTRL: read_val = {25'h0, capb_capture_r, capa_capture_r, capa_sel_r,
                                        edge_sel_b_r, edge_sel_a_r};
            `ADDR_COUNT: read_val = {16'h0, count_register_r};
            `ADDR_CAPCMP_A: read_val = {16'h0, capcmp_reg_a_r};
            `ADDR_CAPCMP_B: read_val = {16'h0, capcmp_reg_b_r};
            `ADDR_STATUS: read_val = {28'h0, pulse_state_r == PULSE_ACTIVE, pin_r, irq_b_r, irq_a_r};
            default: read_val = 32'h0;
        endcase
    end

    // Read data is latched in the setup cycle and stands through the access phase.
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            prdata_r <= 32'h0;
        end else if (rd_en) begin
            prdata_r <= read_val;
        end
    end
endmodule

//--- test/timer_check_assertions.sv
// Checker for the capture timer top: bus answer, pulse timing and capture sources.
// Assumes it is bound to the top module; it mirrors configuration writes itself.
module timer_check #(
    parameter int WIDTH = 16
) (
    // Clock, reset and APB.
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Pins and requests.
    input wire logic TRIGGER_INPUT_A,
    input wire logic TRIGGER_INPUT_B,
    input wire logic PULSE_OUTPUT_PIN,
    input wire logic MATCH_CAPTURE_IRQ_A,
    input wire logic MATCH_CAPTURE_IRQ_B
);
    timeunit 1ns;
    timeprecision 1ps;
    logic wr, osp_r, clean_r, prev_a_r, prev_b_r;
    logic [1:0] mode_r;
    logic [6:0] cap_r;
    logic [15:0] cmp_a_r, cmp_b_r;
    logic [31:0] gap_r, hi_r;
    logic [3:0] age_a_r, age_b_r;
    assign wr = PSEL && PENABLE && PWRITE && PREADY;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);
    always_ff @(posedge CLK_SYS) begin
        if (RESET) begin
            mode_r <= 2'h0;
            osp_r <= 1'b0;
            cap_r <= 7'h00;
        end else if (wr) begin
            case (PADDR)
                12'h000: mode_r <= PWDATA[1:0];
                12'h004: osp_r <= PWDATA[1];
                12'h008: cap_r <= PWDATA[6:0];
                12'h010: cmp_a_r <= PWDATA[15:0];
                12'h014: cmp_b_r <= PWDATA[15:0];
                default: ;
            endcase
        end
    end
    // Any write ends a clean stretch, so timing is judged only after a full period untouched.
    always_ff @(posedge CLK_SYS) begin
        clean_r <= !RESET && !wr && (clean_r || MATCH_CAPTURE_IRQ_A);
        gap_r <= MATCH_CAPTURE_IRQ_A ? 32'h1 : gap_r + 32'h1;
        hi_r <= PULSE_OUTPUT_PIN ? hi_r + 32'h1 : 32'h0;
        prev_a_r <= TRIGGER_INPUT_A;
        prev_b_r <= TRIGGER_INPUT_B;
        age_a_r <= (RESET || TRIGGER_INPUT_A != prev_a_r) ? 4'h0 : age_a_r + {3'h0, age_a_r != 4'hf};
        age_b_r <= (RESET || TRIGGER_INPUT_B != prev_b_r) ? 4'h0 : age_b_r + {3'h0, age_b_r != 4'hf};
    end
    ready_high_a: assert property (PREADY) else $error("bus not ready");
    no_error_a: assert property (!PSLVERR) else $error("bus error raised");
    ppg_period_a: assert property (MATCH_CAPTURE_IRQ_A && clean_r && mode_r == 2'h3 |-> gap_r == cmp_a_r + 32'h1)
        else $error("pulse period wrong");
    ppg_match_b_a: assert property (MATCH_CAPTURE_IRQ_B && clean_r && mode_r == 2'h3 |-> gap_r == cmp_b_r + 32'h1)
        else $error("second match misplaced");
    ppg_width_a: assert property ($fell(PULSE_OUTPUT_PIN) && clean_r && mode_r == 2'h3 |-> hi_r == cmp_b_r + 32'h1)
        else $error("pulse width wrong");
    cap_a_source_a: assert property (MATCH_CAPTURE_IRQ_A && cap_r[5] && mode_r inside {2'h1, 2'h2}
        |-> (cap_r[4] ? age_b_r : age_a_r) inside {[4'h1:4'h6]}) else $error("capture A from wrong pin");
    cap_b_source_a: assert property (MATCH_CAPTURE_IRQ_B && cap_r[6] && mode_r inside {2'h1, 2'h2}
        |-> age_a_r inside {[4'h1:4'h6]}) else $error("capture B from wrong pin");
    single_pin_a: assert property ($changed(PULSE_OUTPUT_PIN) && osp_r && mode_r inside {2'h1, 2'h2}
        |-> MATCH_CAPTURE_IRQ_A || MATCH_CAPTURE_IRQ_B || $past(MATCH_CAPTURE_IRQ_A) || $past(MATCH_CAPTURE_IRQ_B))
        else $error("pin moved without a match");
endmodule
bind capture_timer timer_check #(.WIDTH(WIDTH)) check_u (.CLK_SYS(CLK_SYS), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TRIGGER_INPUT_A(TRIGGER_INPUT_A), .TRIGGER_INPUT_B(TRIGGER_INPUT_B),
    .PULSE_OUTPUT_PIN(PULSE_OUTPUT_PIN), .MATCH_CAPTURE_IRQ_A(MATCH_CAPTURE_IRQ_A),
    .MATCH_CAPTURE_IRQ_B(MATCH_CAPTURE_IRQ_B));

//--- test/trigger_source.sv
// Model of the signal source wired to the two trigger pins.
// Assumes commands arrive as one-cycle strobes on the system clock.
module trigger_source (
    // Clock and commands.
    input wire logic clk,
    input wire logic go_a,
    input wire logic go_b,
    // Pulse pin seen by the source.
    input wire logic pulse_pin,
    // Trigger pins.
    output logic pin_a,
    output logic pin_b
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // A retrigger on pin A while the pulse is high is dropped rather than sent.
    always @(posedge clk) begin
        if (go_a && !pulse_pin) begin
            pin_a <= !pin_a;
        end
        if (go_b) begin
            pin_b <= !pin_b;
        end
    end
endmodule

//--- test/tb.sv
// Self-checking bench for the capture timer: registers, pulse modes and capture.
// Assumes the checker is bound in and the trigger source model drives the pins.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, go_a = 1'b0, go_b = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, v0, v1, v2;
    logic pready, pslverr, trig_a, trig_b, pin, irq_a, irq_b, pin_q;
    int fail_count = 0, checks_done = 0, cyc = 0, na = 0, nb = 0, hi = 0, tg = 0;
    always #2.5 clk = ~clk;
    capture_timer dut_u (.CLK_SYS(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
        .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .TRIGGER_INPUT_A(trig_a),
        .TRIGGER_INPUT_B(trig_b), .PULSE_OUTPUT_PIN(pin), .MATCH_CAPTURE_IRQ_A(irq_a), .MATCH_CAPTURE_IRQ_B(irq_b));
    trigger_source src_u (.clk(clk), .go_a(go_a), .go_b(go_b), .pulse_pin(pin), .pin_a(trig_a), .pin_b(trig_b));
    // Outputs are counted on the falling edge, where they have settled.
    always @(negedge clk) begin
        cyc++;
        na += (irq_a === 1'b1);
        nb += (irq_b === 1'b1);
        hi += (pin === 1'b1);
        tg += (pin !== pin_q);
        pin_q = pin;
    end
    initial begin
        wait (cyc >= 90000);
        fail_count++;
        summarize();
    end
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic clr;
        na = 0;
        nb = 0;
        hi = 0;
        tg = 0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0, r);
    endtask
    task automatic tog(input logic b);
        @(posedge clk);
        go_a <= !b;
        go_b <= b;
        @(posedge clk);
        go_a <= 1'b0;
        go_b <= 1'b0;
    endtask
    task automatic restart(input logic [31:0] mode, input logic [31:0] cap, input logic [31:0] a, input logic [31:0] b);
        @(posedge clk);
        rst <= 1'b1;
        step(2);
        rst <= 1'b0;
        wr(12'h008, cap);
        wr(12'h010, a);
        wr(12'h014, b);
        wr(12'h000, mode);
    endtask
    task automatic meas(input logic b, input int gap, input logic [11:0] a, output logic [31:0] f,
        output logic [31:0] s);
        tog(b);
        step(10);
        rd(a, f);
        step(gap - 15);
        tog(b);
        step(10);
        rd(a, s);
    endtask
    task automatic t_bus;
        restart(32'h0, 32'h0, 32'h0, 32'h0);
        wr(12'h01c, 32'h5a5a5a5a);
        rd(12'h01c, v0);
        chk(v0, 32'h0);
        wr(12'h00c, 32'h1234);
        rd(12'h00c, v0);
        chk(v0, 32'h0);
        wr(12'h000, 32'h1);
        rd(12'h00c, v0);
        rd(12'h00c, v1);
        chk(v1 - v0, 32'h3);
    endtask
    task automatic t_pulse;
        restart(32'h3, 32'h0, 32'h9, 32'h3);
        wr(12'h004, 32'h1);
        step(20);
        clr();
        step(100);
        chk(na, 32'ha);
        chk(nb, 32'ha);
        chk(hi, 32'h28);
        restart(32'h1, 32'h1, 32'h14, 32'h8);
        clr();
        wr(12'h004, 32'h3);
        wr(12'h004, 32'h7);
        step(100);
        chk(hi, 32'hc);
        chk(tg, 32'h2);
        tog(1'b0);
        step(100);
        chk(hi, 32'h18);
        chk(tg, 32'h4);
    endtask
    task automatic t_cap;
        restart(32'h1, 32'h7f, 32'h0, 32'h0);
        meas(1'b1, 50, 12'h010, v0, v1);
        chk((v1 - v0) & 32'hffff, 32'h32);
        meas(1'b0, 30, 12'h014, v0, v2);
        chk((v2 - v0) & 32'hffff, 32'h1e);
        restart(32'h1, 32'h61, 32'h0, 32'h0);
        tog(1'b0);
        step(18);
        tog(1'b0);
        step(10);
        rd(12'h010, v0);
        rd(12'h014, v1);
        chk((v1 - v0) & 32'hffff, 32'h14);
        restart(32'h2, 32'h43, 32'h0, 32'h0);
        meas(1'b0, 40, 12'h014, v0, v1);
        meas(1'b0, 60, 12'h014, v0, v2);
        chk((v2 - v1) & 32'hffff, 32'h14);
    endtask
    // A period one full range longer than a short one must read back the same value with overflow set.
    task automatic t_ovf;
        restart(32'h2, 32'h43, 32'h0, 32'h0);
        meas(1'b0, 40, 12'h014, v0, v1);
        rd(12'h000, v0);
        chk(v0 & 32'h4, 32'h0);
        meas(1'b0, 65576, 12'h014, v0, v2);
        rd(12'h000, v0);
        chk(v0 & 32'h4, 32'h4);
        chk(v2 + 32'h10000 - v1, 32'h10000);
        wr(12'h000, 32'h2);
        rd(12'h000, v0);
        chk(v0 & 32'h4, 32'h0);
    endtask
    initial begin
        step(12);
        rst <= 1'b0;
        t_bus();
        t_pulse();
        t_cap();
        t_ovf();
        summarize();
    end
endmodule
